// ### rtl/msim_pkg.sv
/*
  Package for the mute and stop input monitor: timing constants and states.
  Assumes a 100 MHz clock.
*/
package msim_pkg;
  localparam int unsigned CLK_MHZ = 100;
  // Simultaneity windows in milliseconds
  localparam int unsigned MUTE_SIMUL_MS = 3000;
  localparam int unsigned STOP_SIMUL_MS = 3000;
  // Reset press window in milliseconds
  localparam int unsigned RESET_MIN_MS = 250;
  localparam int unsigned RESET_MAX_MS = 2000;
  // Lamp flash half period in milliseconds
  localparam int unsigned FLASH_HALF_MS = 250;
  localparam int unsigned MUTE_SIMUL_CYC = MUTE_SIMUL_MS * CLK_MHZ * 1000;
  localparam int unsigned STOP_SIMUL_CYC = STOP_SIMUL_MS * CLK_MHZ * 1000;
  localparam int unsigned RESET_MIN_CYC = RESET_MIN_MS * CLK_MHZ * 1000;
  localparam int unsigned RESET_MAX_CYC = RESET_MAX_MS * CLK_MHZ * 1000;
  localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 32;
  // Stop channel pair monitor states
  typedef enum logic [1:0] {
    MSIM_CH_OFF = 2'b00,
    MSIM_CH_ON = 2'b01,
    MSIM_CH_WAIT = 2'b10,
    MSIM_CH_LOCK = 2'b11
  } msim_ch_t;
endpackage

// ### rtl/msim_monitor.sv
/*
  Mute and stop input monitor: two-channel stop inputs, muting pairs,
  lamp and auxiliary outputs.
  Assumes all inputs are synchronous and debounced; 1 = closed/active.
*/
`timescale 1ns/1ps
`default_nettype none
module msim_monitor
  import msim_pkg::*;
#(
  parameter int unsigned MUTE_SIMUL = MUTE_SIMUL_CYC,
  parameter int unsigned STOP_SIMUL = STOP_SIMUL_CYC,
  parameter int unsigned RESET_MIN = RESET_MIN_CYC,
  parameter int unsigned RESET_MAX = RESET_MAX_CYC,
  parameter int unsigned FLASH_HALF = FLASH_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic safetyStopInputA,
  input wire logic safetyStopInputB,
  input wire logic muteableStopInputA,
  input wire logic muteableStopInputB,
  input wire logic muteSensorOne,
  input wire logic muteSensorTwo,
  input wire logic muteSensorThree,
  input wire logic muteSensorFour,
  input wire logic muteEnable,
  input wire logic overrideActive,
  input wire logic manualResetMode,
  input wire logic resetButton,
  input wire logic lampMonitorSelectA,
  input wire logic lampMonitorSelectB,
  input wire logic lampSense,
  output logic safetySwitchingOutputs,
  output logic auxOutput,
  output logic muteLampOutput,
  output logic lockout,
  output logic muted
);

  ////////////////////////////////////////////////////////////////////////
  // Reset button press window

  logic [CNT_W-1:0] rstCnt_reg;
  logic resetPrev_reg;
  logic validReset;

  // Count press length
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rstCnt_reg <= '0;
      resetPrev_reg <= 1'b0;
    end else begin
      resetPrev_reg <= resetButton;
      if (resetButton && rstCnt_reg != '1) begin
        rstCnt_reg <= rstCnt_reg + 1'b1;
      end else if (!resetButton) begin
        rstCnt_reg <= '0;
      end
    end
  end

  // Release inside the window is a valid reset
  assign validReset = resetPrev_reg && !resetButton && rstCnt_reg >= RESET_MIN
                      && rstCnt_reg <= RESET_MAX;

  ////////////////////////////////////////////////////////////////////////
  // Two-channel stop monitors: index 0 ordinary, 1 muteable

  logic [1:0] chA;
  logic [1:0] chB;
  logic [1:0] chOk;
  logic [1:0] chLock;
  logic [1:0] chNeedReset;
  assign chA = {muteableStopInputA, safetyStopInputA};
  assign chB = {muteableStopInputB, safetyStopInputB};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gCh
      msim_ch_t st_reg;
      logic [CNT_W-1:0] cnt_reg;
      logic pend_reg;
      // Simultaneity on opening and closing
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          st_reg <= MSIM_CH_OFF;
          cnt_reg <= '0;
          pend_reg <= 1'b0;
        end else begin
          case (st_reg)
            MSIM_CH_OFF: begin
              cnt_reg <= '0;
              if (chA[gi] && chB[gi]) begin
                st_reg <= MSIM_CH_ON;
              end else if (chA[gi] != chB[gi]) begin
                st_reg <= MSIM_CH_WAIT;
              end
            end
            MSIM_CH_ON: begin
              cnt_reg <= '0;
              if (!chA[gi] && !chB[gi]) begin
                st_reg <= MSIM_CH_OFF;
              end else if (chA[gi] != chB[gi]) begin
                st_reg <= MSIM_CH_WAIT;
              end
            end
            MSIM_CH_WAIT: begin
              cnt_reg <= cnt_reg + 1'b1;
              if (chA[gi] && chB[gi]) begin
                st_reg <= MSIM_CH_ON;
              end else if (!chA[gi] && !chB[gi]) begin
                st_reg <= MSIM_CH_OFF;
              end else if (cnt_reg >= STOP_SIMUL - 1) begin
                st_reg <= MSIM_CH_LOCK;
                pend_reg <= 1'b0;
              end
            end
            MSIM_CH_LOCK: begin
              // Need both open, then both closed together
              if (!chA[gi] && !chB[gi]) begin
                pend_reg <= 1'b1;
              end else if (pend_reg && chA[gi] && chB[gi]) begin
                st_reg <= MSIM_CH_ON;
              end
            end
            default: st_reg <= MSIM_CH_LOCK;
          endcase
        end
      end
      assign chOk[gi] = (st_reg == MSIM_CH_ON);
      assign chLock[gi] = (st_reg == MSIM_CH_LOCK);
      assign chNeedReset[gi] = (st_reg == MSIM_CH_LOCK) && pend_reg && chA[gi] && chB[gi];
    end
  endgenerate

  // Latch pending manual reset after a lockout cleared
  logic latch_reg;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latch_reg <= 1'b1;
    end else if (|chLock || |chNeedReset) begin
      latch_reg <= manualResetMode;
    end else if (!manualResetMode || validReset) begin
      latch_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Muting pair simultaneity

  logic [1:0] pairA;
  logic [1:0] pairB;
  logic [1:0] pairGood;
  assign pairA = {muteSensorThree, muteSensorOne};
  assign pairB = {muteSensorFour, muteSensorTwo};

  generate
    for (gi = 0; gi < 2; gi++) begin : gPair
      logic [CNT_W-1:0] pc_reg;
      logic good_reg;
      // Time from first to second sensor of the pair
      always_ff @(posedge clk) begin
        if (!reset_n) begin
          pc_reg <= '0;
          good_reg <= 1'b0;
        end else if (!pairA[gi] && !pairB[gi]) begin
          pc_reg <= '0;
          good_reg <= 1'b0;
        end else if (pairA[gi] && pairB[gi]) begin
          if (pc_reg < MUTE_SIMUL) begin
            good_reg <= 1'b1;
          end
        end else begin
          good_reg <= 1'b0;
          if (pc_reg != '1) begin
            pc_reg <= pc_reg + 1'b1;
          end
        end
      end
      assign pairGood[gi] = good_reg && pairA[gi] && pairB[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Muting and outputs

  logic lampMonitored;
  logic lampFail;
  logic muteNow;
  logic runNow;
  logic [CNT_W-1:0] flashCnt_reg;
  logic flash_reg;
  assign lampMonitored = !lampMonitorSelectA && !lampMonitorSelectB;
  assign lampFail = lampMonitored && !lampSense;
  assign muteNow = muteEnable && |pairGood && !lampFail && !(|chLock) && !latch_reg;
  // Ordinary input always stops; muteable one bypassed when muted
  assign runNow = chOk[0] && (chOk[1] || muteNow) && !(|chLock) && !latch_reg;

  // Flash timebase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flashCnt_reg <= '0;
      flash_reg <= 1'b0;
    end else if (flashCnt_reg >= FLASH_HALF - 1) begin
      flashCnt_reg <= '0;
      flash_reg <= !flash_reg;
    end else begin
      flashCnt_reg <= flashCnt_reg + 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      safetySwitchingOutputs <= 1'b0;
      auxOutput <= 1'b0;
      muteLampOutput <= 1'b0;
      lockout <= 1'b0;
      muted <= 1'b0;
    end else begin
      safetySwitchingOutputs <= runNow;
      auxOutput <= runNow;
      muted <= muteNow;
      lockout <= |chLock;
      if (overrideActive) begin
        muteLampOutput <= flash_reg;
      end else begin
        muteLampOutput <= muteNow;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  // Helper state for the checks: run of any channel mismatch
  logic chMismatch;
  logic anyPairGood;
  logic [CNT_W-1:0] mismatchCnt_reg;
  assign chMismatch = (chA != chB);
  assign anyPairGood = |pairGood;
  always_ff @(posedge clk) begin
    if (!reset_n || !chMismatch) begin
      mismatchCnt_reg <= '0;
    end else if (mismatchCnt_reg != '1) begin
      mismatchCnt_reg <= mismatchCnt_reg + 1'b1;
    end
  end

  AST_AUX_FOLLOWS: assert property (@(posedge clk) disable iff (!reset_n)
    auxOutput == safetySwitchingOutputs) else $error("aux differs from safety outputs");
  AST_LOCK_OFF: assert property (@(posedge clk) disable iff (!reset_n)
    lockout |-> !safetySwitchingOutputs) else $error("outputs on in lockout");
  AST_LOCK_NOMUTE: assert property (@(posedge clk) disable iff (!reset_n)
    |chLock |=> !muted) else $error("muted in lockout");
  AST_LAMP_MUTED: assert property (@(posedge clk) disable iff (!reset_n)
    !overrideActive |=> muteLampOutput == $past(muteNow)) else $error("lamp wrong");
  AST_LAMP_FLASH: assert property (@(posedge clk) disable iff (!reset_n)
    overrideActive |=> muteLampOutput == $past(flash_reg)) else $error("lamp not flashing");
  AST_LAMP_FAIL: assert property (@(posedge clk) disable iff (!reset_n)
    lampFail |=> !muted) else $error("muted with failed lamp");
  AST_STOP_ALWAYS: assert property (@(posedge clk) disable iff (!reset_n)
    !chOk[0] |=> !safetySwitchingOutputs) else $error("ordinary stop ignored");
  AST_RUN_MUTEABLE_STOP_INPUT: assert property (@(posedge clk) disable iff (!reset_n)
    !chOk[1] && !muteNow |=> !safetySwitchingOutputs) else $error("muteable stop ignored");
  AST_UNMON_LAMP: assert property (@(posedge clk) disable iff (!reset_n)
    lampMonitorSelectA && lampMonitorSelectB && muteEnable && anyPairGood && !(|chLock) && !latch_reg
    |=> muted) else $error("unmonitored lamp blocked muting");
  AST_LOCK_ENTRY: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(lockout) |-> $past(chMismatch, 2)) else $error("lockout without mismatch");
  AST_LOCK_LATE: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(lockout) |-> mismatchCnt_reg >= STOP_SIMUL) else $error("lockout too early");
  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    latch_reg |=> !safetySwitchingOutputs) else $error("outputs on while latched");
  AST_MUTE_PAIR: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(muted) |-> $past(anyPairGood)) else $error("mute without pair");
  AST_MUTE_ENABLE: assert property (@(posedge clk) disable iff (!reset_n)
    !muteEnable |=> !muted) else $error("muted while not enabled");

  COV_MUTED: cover property (@(posedge clk) disable iff (!reset_n) $rose(muted));
  COV_LOCK: cover property (@(posedge clk) disable iff (!reset_n) $rose(lockout));
  COV_RUN: cover property (@(posedge clk) disable iff (!reset_n) $rose(safetySwitchingOutputs));
  COV_RESET: cover property (@(posedge clk) disable iff (!reset_n) validReset);
  COV_FLASH: cover property (@(posedge clk) disable iff (!reset_n) overrideActive && muteLampOutput);

endmodule // msim_monitor
`default_nettype wire

// ### tb/msim_field.sv
/*
  Field-side model: stop switch channels, mute sensors, reset switch, lamp.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module msim_field (
  input wire logic clk,
  output logic [1:0] safety_stop_input,
  output logic [1:0] muteable_stop_input,
  output logic [3:0] sense,
  output logic resetButton,
  output logic lampSense
);
  logic lampOk;
  ////////////////////////////////////////////////////////////////
  // Ordinary stop input closed, guard closed, lamp healthy
  initial begin
    safety_stop_input = 2'b11;
    muteable_stop_input = 2'b11;
    sense = 4'h0;
    resetButton = 1'b0;
    lampOk = 1'b1;
  end
  // Lamp current sense follows lamp health
  assign lampSense = lampOk;
  // Switch and sensor levels
  task automatic set(input logic [1:0] s, input logic [1:0] m, input logic [3:0] n);
    safety_stop_input = s;
    muteable_stop_input = m;
    sense = n;
  endtask
  // Reset switch closed for n cycles, then opened
  task automatic press(input int n);
    resetButton = 1'b1;
    repeat (n) @(posedge clk);
    #1 resetButton = 1'b0;
  endtask
endmodule // msim_field
`default_nettype wire

// ### tb/msim_monitor_tb_top.sv
/*
  Self-checking bench for the mute and stop input monitor.
  Assumes short timing parameters 20, 20, 4, 10, 3 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module msim_monitor_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic muteEnable;
  logic overrideActive;
  logic manualResetMode;
  logic lampMonitorSelectA;
  logic lampMonitorSelectB;
  logic [1:0] safety_stop_input, muteable_stop_input;
  logic [3:0] sense;
  logic resetButton, lampSense, safetySwitchingOutputs, auxOutput, muteLampOutput, lockout, muted;
  int fails = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  msim_field i_msim_field (.clk(clk), .safety_stop_input(safety_stop_input), .muteable_stop_input(muteable_stop_input), .sense(sense), .resetButton(resetButton),
    .lampSense(lampSense));
  msim_monitor #(.MUTE_SIMUL(20), .STOP_SIMUL(20), .RESET_MIN(4), .RESET_MAX(10), .FLASH_HALF(3))
  i_msim_monitor (.clk(clk), .reset_n(reset_n), .safetyStopInputA(safety_stop_input[1]), .safetyStopInputB(safety_stop_input[0]),
    .muteableStopInputA(muteable_stop_input[1]), .muteableStopInputB(muteable_stop_input[0]), .muteSensorOne(sense[0]),
    .muteSensorTwo(sense[1]), .muteSensorThree(sense[2]), .muteSensorFour(sense[3]),
    .muteEnable(muteEnable), .overrideActive(overrideActive), .manualResetMode(manualResetMode),
    .resetButton(resetButton), .lampMonitorSelectA(lampMonitorSelectA),
    .lampMonitorSelectB(lampMonitorSelectB), .lampSense(lampSense),
    .safetySwitchingOutputs(safetySwitchingOutputs), .auxOutput(auxOutput),
    .muteLampOutput(muteLampOutput), .lockout(lockout), .muted(muted));
  ////////////////////////////////////////////////////////////////
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One sensor, a gap, then both; muted and lamp judged
  task automatic pairTry(input logic [3:0] first, input logic [3:0] both, input int gap, input logic exp);
    i_msim_field.set(2'b11, 2'b11, first);
    cyc(gap);
    i_msim_field.set(2'b11, 2'b11, both);
    cyc(5);
    check("muted", exp, muted);
    check("muteLampOutput", exp, muteLampOutput);
  endtask
  task automatic release_all;
    i_msim_field.set(2'b11, 2'b11, 4'h0);
    cyc(5);
  endtask
  ////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_mute;
    pairTry(4'h1, 4'h3, 5, 1'b1);
    i_msim_field.set(2'b11, 2'b00, 4'h3);
    cyc(5);
    check("safetySwitchingOutputs", 1'b1, safetySwitchingOutputs);
    i_msim_field.set(2'b00, 2'b11, 4'h3);
    cyc(5);
    check("safetySwitchingOutputs", 1'b0, safetySwitchingOutputs);
    check("auxOutput", 1'b0, auxOutput);
    release_all();
    pairTry(4'h4, 4'hc, 5, 1'b1);
    release_all();
    pairTry(4'h1, 4'h3, 30, 1'b0);
    release_all();
    muteEnable = 1'b0;
    pairTry(4'h1, 4'h3, 3, 1'b0);
    release_all();
    muteEnable = 1'b1;
  endtask
  task automatic t_override;
    int ones;
    ones = 0;
    pairTry(4'h4, 4'hc, 3, 1'b1);
    overrideActive = 1'b1;
    cyc(3);
    repeat (12) begin
      cyc(1);
      ones += int'(muteLampOutput === 1'b1);
    end
    check("lamp flashing", 1'b1, ones > 0 && ones < 12);
    overrideActive = 1'b0;
    release_all();
  endtask
  task automatic t_lamp;
    i_msim_field.lampOk = 1'b0;
    pairTry(4'h1, 4'h3, 3, 1'b0);
    release_all();
    {lampMonitorSelectA, lampMonitorSelectB} = 2'b11;
    pairTry(4'h1, 4'h3, 3, 1'b1);
    release_all();
    {lampMonitorSelectA, lampMonitorSelectB} = 2'b00;
    i_msim_field.lampOk = 1'b1;
  endtask
  task automatic t_lock;
    i_msim_field.set(2'b11, 2'b10, 4'h0);
    cyc(10);
    i_msim_field.set(2'b11, 2'b11, 4'h0);
    cyc(5);
    check("lockout", 1'b0, lockout);
    i_msim_field.set(2'b11, 2'b10, 4'h3);
    cyc(30);
    check("lockout", 1'b1, lockout);
    check("safetySwitchingOutputs", 1'b0, safetySwitchingOutputs);
    check("muted", 1'b0, muted);
    i_msim_field.set(2'b11, 2'b00, 4'h0);
    cyc(5);
    i_msim_field.set(2'b11, 2'b11, 4'h0);
    cyc(5);
    check("lockout", 1'b0, lockout);
    check("auxOutput", 1'b1, auxOutput);
  endtask
  task automatic t_manual;
    manualResetMode = 1'b1;
    i_msim_field.set(2'b10, 2'b11, 4'h0);
    cyc(30);
    check("lockout", 1'b1, lockout);
    i_msim_field.set(2'b00, 2'b11, 4'h0);
    cyc(5);
    i_msim_field.set(2'b11, 2'b11, 4'h0);
    cyc(5);
    check("safetySwitchingOutputs", 1'b0, safetySwitchingOutputs);
    i_msim_field.press(2);
    cyc(5);
    check("safetySwitchingOutputs", 1'b0, safetySwitchingOutputs);
    i_msim_field.press(6);
    cyc(5);
    check("safetySwitchingOutputs", 1'b1, safetySwitchingOutputs);
    manualResetMode = 1'b0;
  endtask
  // Mid-run reset in manual mode: outputs stay off until a valid press
  task automatic t_reset;
    manualResetMode = 1'b1;
    reset_n = 1'b0;
    cyc(4);
    check("safetySwitchingOutputs", 1'b0, safetySwitchingOutputs);
    reset_n = 1'b1;
    cyc(10);
    check("lockout", 1'b0, lockout);
    check("safetySwitchingOutputs", 1'b0, safetySwitchingOutputs);
    i_msim_field.press(6);
    cyc(5);
    check("safetySwitchingOutputs", 1'b1, safetySwitchingOutputs);
    check("auxOutput", 1'b1, auxOutput);
    manualResetMode = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    muteEnable = 1'b1;
    overrideActive = 1'b0;
    manualResetMode = 1'b0;
    lampMonitorSelectA = 1'b0;
    lampMonitorSelectB = 1'b0;
    repeat (4) @(posedge clk);
    #1 reset_n = 1'b1;
    cyc(5);
    check("auxOutput", 1'b1, auxOutput);
    t_mute();
    t_override();
    t_lamp();
    t_lock();
    t_manual();
    t_reset();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule // msim_monitor_tb_top
`default_nettype wire
